// ### pkg/pis_pkg.sv
// Shared constants and types for the physical interrupt signaling block
package pis_pkg;

    // Default sizes of the block
    localparam int DOM_W     = 2;
    localparam int PRI_W     = 5;
    localparam int ID_W      = 24;
    localparam int NUM_DOM   = 4;
    localparam int NUM_LOCAL = 16;

    // Domain number of the monitor-level domain
    localparam logic [1:0] DOM_MONITOR = 2'h0;

    // Identifier type field placed above the local interrupt index
    localparam int         ID_TYPE_W     = 3;
    localparam logic [2:0] ID_TYPE_LOCAL = 3'h1;

    // Priority value that qualifies for superpriority
    localparam logic [4:0] PRI_SUPER = 5'h00;

    // Reset values of registered outputs
    localparam logic RST_LINE  = 1'b0;
    localparam logic RST_VALID = 1'b0;

    // Settle time of the three register stages, in core clock cycles
    localparam int SETTLE_CYCLES = 3;

    // Class of the line to be signalled to the processing element
    typedef enum logic [1:0] {
        SIG_NONE   = 2'b00,
        SIG_NORMAL = 2'b01,
        SIG_FAST   = 2'b10
    } pis_sig_type;

endpackage

// ### design/pis_local_select.sv
// Best local per-core interrupt for each domain, registered
`timescale 1ns/1ps
`default_nettype none
module pis_local_select #(
    parameter int NUM_LOCAL = pis_pkg::NUM_LOCAL,
    parameter int NUM_DOM   = pis_pkg::NUM_DOM,
    parameter int PRI_W     = pis_pkg::PRI_W,
    parameter int ID_W      = pis_pkg::ID_W,
    parameter int DOM_W     = pis_pkg::DOM_W
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [NUM_DOM-1:0]         domain_enable,
    input  wire logic [NUM_LOCAL-1:0]       local_pending,
    input  wire logic [NUM_LOCAL-1:0]       local_enable,
    input  wire logic [NUM_LOCAL*PRI_W-1:0] local_priority,
    input  wire logic [NUM_LOCAL*DOM_W-1:0] local_domain,
    output logic      [NUM_DOM-1:0]         best_valid_q,
    output logic      [NUM_DOM*PRI_W-1:0]   best_pri_q,
    output logic      [NUM_DOM*ID_W-1:0]    best_id_q
);
    localparam int IDX_W = ID_W - pis_pkg::ID_TYPE_W;

    // ========================================================
    // Per-domain search, lowest index wins a priority tie
    genvar d;
    generate
        for (d = 0; d < NUM_DOM; d = d + 1) begin : g_dom
            logic             valid_d;
            logic [PRI_W-1:0] pri_d;
            logic [ID_W-1:0]  id_d;

            // Scan all local interrupts assigned here
            always_comb begin
                valid_d = 1'b0;
                pri_d   = '0;
                id_d    = '0;
                for (int i = 0; i < NUM_LOCAL; i++) begin
                    if (domain_enable[d] && local_pending[i] &&
                        local_enable[i] &&
                        int'(local_domain[i*DOM_W +: DOM_W]) == d &&
                        (!valid_d ||
                         local_priority[i*PRI_W +: PRI_W] < pri_d)) begin
                        valid_d = 1'b1;
                        pri_d   = local_priority[i*PRI_W +: PRI_W];
                        id_d    = {pis_pkg::ID_TYPE_LOCAL, IDX_W'(i)};
                    end
                end
            end

            // Hold the winner for the domain merge
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    best_valid_q[d]                <= pis_pkg::RST_VALID;
                    best_pri_q[d*PRI_W +: PRI_W]   <= '0;
                    best_id_q[d*ID_W +: ID_W]      <= '0;
                end else begin
                    best_valid_q[d]                <= valid_d;
                    best_pri_q[d*PRI_W +: PRI_W]   <= pri_d;
                    best_id_q[d*ID_W +: ID_W]      <= id_d;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### design/pis_domain_eval.sv
// Merge of upstream and local candidates and masking for one domain
`timescale 1ns/1ps
`default_nettype none
module pis_domain_eval #(
    parameter int PRI_W = pis_pkg::PRI_W,
    parameter int ID_W  = pis_pkg::ID_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             domain_enable,
    input  wire logic             up_valid,
    input  wire logic [PRI_W-1:0] up_priority,
    input  wire logic [ID_W-1:0]  up_identifier,
    input  wire logic             loc_valid,
    input  wire logic [PRI_W-1:0] loc_priority,
    input  wire logic [ID_W-1:0]  loc_identifier,
    input  wire logic [PRI_W-1:0] priority_mask,
    input  wire logic [PRI_W-1:0] running_priority,
    output logic                  highest_priority_pending_valid_q,
    output logic      [PRI_W-1:0] highest_priority_pending_pri_q,
    output logic      [ID_W-1:0]  highest_priority_pending_id_q,
    output logic                  sufficient_q
);
    logic             take_up;
    logic             valid_d;
    logic [PRI_W-1:0] pri_d;
    logic [ID_W-1:0]  id_d;
    logic             suff_d;

    // ========================================================
    // Candidate merge, upstream wins a priority tie
    always_comb begin
        take_up = up_valid && (!loc_valid || up_priority <= loc_priority);
        valid_d = domain_enable && (up_valid || loc_valid);
        pri_d   = take_up ? up_priority : loc_priority;
        id_d    = take_up ? up_identifier : loc_identifier;
        // Both the mask and the running priority must be beaten
        suff_d  = valid_d && pri_d < priority_mask &&
                  pri_d < running_priority;
    end

    // ========================================================
    // Registered result, refreshed every cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            highest_priority_pending_valid_q <= pis_pkg::RST_VALID;
            highest_priority_pending_pri_q   <= '0;
            highest_priority_pending_id_q    <= '0;
            sufficient_q <= pis_pkg::RST_VALID;
        end else begin
            highest_priority_pending_valid_q <= valid_d;
            highest_priority_pending_pri_q   <= pri_d;
            highest_priority_pending_id_q    <= id_d;
            sufficient_q <= suff_d;
        end
    end
endmodule
`default_nettype wire

// ### design/pis_signaling.sv
// Physical interrupt signaling: per-domain selection, lines and reports
// Operation
// - Evaluate a domain only while it is enabled
// - Pick higher of upstream and local candidate
// - Disabled domain has no candidates, no pending
// - Equal priority: upstream candidate is taken
// - Pending interrupt settles in bounded cycles
// - Recompute on local or upstream change
// - Mask against priority mask and running priority
// - Fast line: preemptive, or monitor with any
// - Normal line: non-monitor, no preemptive, own pending
// - Fast and normal never asserted together
// - Lower report shows current domain below monitor
// - At monitor level lower report follows select
// - Reports carry identifier when pending shown
// - Reports show only sufficient-priority interrupts
// - Top report shows monitor-level domain
// - Summary shows each other domain's pending
// - Single domain configuration never asserts fast
// - Preemptive: preemptive domain and above threshold
// - Unimplemented preemptive select means no preemption
// - Superpriority: priority zero with nonmaskable enable
`timescale 1ns/1ps
`default_nettype none
module pis_signaling #(
    parameter int NUM_DOM   = pis_pkg::NUM_DOM,
    parameter int NUM_LOCAL = pis_pkg::NUM_LOCAL,
    parameter int PRI_W     = pis_pkg::PRI_W,
    parameter int ID_W      = pis_pkg::ID_W,
    parameter int DOM_W     = pis_pkg::DOM_W
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [NUM_DOM-1:0]         domain_enable,
    input  wire logic [NUM_DOM-1:0]         upstream_valid,
    input  wire logic [NUM_DOM*PRI_W-1:0]   upstream_priority,
    input  wire logic [NUM_DOM*ID_W-1:0]    upstream_identifier,
    input  wire logic [NUM_LOCAL-1:0]       local_pending,
    input  wire logic [NUM_LOCAL-1:0]       local_enable,
    input  wire logic [NUM_LOCAL*PRI_W-1:0] local_priority,
    input  wire logic [NUM_LOCAL*DOM_W-1:0] local_domain,
    input  wire logic [NUM_DOM*PRI_W-1:0]   priority_mask,
    input  wire logic [NUM_DOM*PRI_W-1:0]   running_priority,
    input  wire logic [NUM_DOM*PRI_W-1:0]   preemption_threshold,
    input  wire logic [DOM_W-1:0]           preemptive_domain_select,
    input  wire logic [DOM_W-1:0]           current_domain,
    input  wire logic                       at_monitor_level,
    input  wire logic [DOM_W-1:0]           security_state_select,
    input  wire logic                       nonmaskable_enable_monitor,
    input  wire logic                       nonmaskable_enable_routed,
    output logic                            fast_interrupt_line_q,
    output logic                            normal_interrupt_line_q,
    output logic                            superpriority_q,
    output logic                            lower_report_valid_q,
    output logic      [ID_W-1:0]            lower_report_id_q,
    output logic                            top_report_valid_q,
    output logic      [ID_W-1:0]            top_report_id_q,
    output logic      [NUM_DOM-1:0]         domain_pending_summary_q
);
    // Local best candidate of each domain
    logic [NUM_DOM-1:0]       loc_valid;
    logic [NUM_DOM*PRI_W-1:0] loc_pri;
    logic [NUM_DOM*ID_W-1:0]  loc_id;

    // Merged and masked result of each domain
    logic [NUM_DOM*PRI_W-1:0] highest_priority_pending_pri;
    logic [NUM_DOM*ID_W-1:0]  highest_priority_pending_id;
    logic [NUM_DOM-1:0]       suff;

    // Decision terms
    logic                     pid_impl;
    logic                     preempt_exists;
    logic                     cur_is_monitor;
    logic                     any_suff;
    logic                     cur_suff;
    logic [DOM_W-1:0]         report_dom;
    logic                     super_d;
    logic [NUM_DOM-1:0]       summary_d;
    pis_pkg::pis_sig_type     sig_d;

    // Priority field of one domain from a packed vector
    function automatic logic [PRI_W-1:0] dom_pri(
        input logic [NUM_DOM*PRI_W-1:0] vec,
        input logic [DOM_W-1:0]         dom
    );
        dom_pri = vec[int'(dom)*PRI_W +: PRI_W];
    endfunction

    // True when a domain number names an implemented domain
    function automatic logic dom_impl(input logic [DOM_W-1:0] dom);
        dom_impl = int'(dom) < NUM_DOM;
    endfunction

    // ========================================================
    // Stage one: best local interrupt per domain
    pis_local_select #(
        .NUM_LOCAL (NUM_LOCAL),
        .NUM_DOM   (NUM_DOM),
        .PRI_W     (PRI_W),
        .ID_W      (ID_W),
        .DOM_W     (DOM_W)
    ) u_local (
        .clk_sys        (clk_sys),
        .rst_n          (rst_n),
        .domain_enable  (domain_enable),
        .local_pending  (local_pending),
        .local_enable   (local_enable),
        .local_priority (local_priority),
        .local_domain   (local_domain),
        .best_valid_q   (loc_valid),
        .best_pri_q     (loc_pri),
        .best_id_q      (loc_id)
    );

    // ========================================================
    // Stage two: merge with upstream and mask, one per domain
    genvar d;
    generate
        for (d = 0; d < NUM_DOM; d = d + 1) begin : g_dom
            pis_domain_eval #(
                .PRI_W (PRI_W),
                .ID_W  (ID_W)
            ) u_eval (
                .clk_sys          (clk_sys),
                .rst_n            (rst_n),
                .domain_enable    (domain_enable[d]),
                .up_valid         (upstream_valid[d]),
                .up_priority      (upstream_priority[d*PRI_W +: PRI_W]),
                .up_identifier    (upstream_identifier[d*ID_W +: ID_W]),
                .loc_valid        (loc_valid[d]),
                .loc_priority     (loc_pri[d*PRI_W +: PRI_W]),
                .loc_identifier   (loc_id[d*ID_W +: ID_W]),
                .priority_mask    (priority_mask[d*PRI_W +: PRI_W]),
                .running_priority (running_priority[d*PRI_W +: PRI_W]),
                .highest_priority_pending_valid_q     (),
                .highest_priority_pending_pri_q       (highest_priority_pending_pri[d*PRI_W +: PRI_W]),
                .highest_priority_pending_id_q        (highest_priority_pending_id[d*ID_W +: ID_W]),
                .sufficient_q     (suff[d])
            );
        end
    endgenerate

    // ========================================================
    // Preemption test on the selected preemptive domain
    always_comb begin
        pid_impl       = dom_impl(preemptive_domain_select);
        preempt_exists = 1'b0;
        if (pid_impl) begin
            // Only the preemptive domain, and only above its threshold
            preempt_exists = suff[preemptive_domain_select] &&
                dom_pri(highest_priority_pending_pri, preemptive_domain_select) <
                dom_pri(preemption_threshold,
                        preemptive_domain_select);
        end
    end

    // Current domain and any-domain pending terms
    always_comb begin
        cur_is_monitor = current_domain == pis_pkg::DOM_MONITOR;
        any_suff       = |suff;
        cur_suff       = dom_impl(current_domain) && suff[current_domain];
    end

    // ========================================================
    // Line class: fast wins, then normal, else none
    always_comb begin
        sig_d = pis_pkg::SIG_NONE;
        if (NUM_DOM > 1 &&
            (preempt_exists || (cur_is_monitor && any_suff))) begin
            sig_d = pis_pkg::SIG_FAST;
        end else if (!cur_is_monitor && !preempt_exists && cur_suff) begin
            sig_d = pis_pkg::SIG_NORMAL;
        end
    end

    // Registered lines decoded from one class, so never both
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fast_interrupt_line_q   <= pis_pkg::RST_LINE;
            normal_interrupt_line_q <= pis_pkg::RST_LINE;
        end else begin
            case (sig_d)
                pis_pkg::SIG_FAST: begin
                    fast_interrupt_line_q   <= 1'b1;
                    normal_interrupt_line_q <= 1'b0;
                end
                pis_pkg::SIG_NORMAL: begin
                    fast_interrupt_line_q   <= 1'b0;
                    normal_interrupt_line_q <= 1'b1;
                end
                default: begin
                    fast_interrupt_line_q   <= 1'b0;
                    normal_interrupt_line_q <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // Superpriority of the current domain's pending interrupt
    always_comb begin
        super_d = cur_suff &&
            dom_pri(highest_priority_pending_pri, current_domain) == pis_pkg::PRI_SUPER &&
            (cur_is_monitor ? nonmaskable_enable_monitor
                            : nonmaskable_enable_routed);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            superpriority_q <= pis_pkg::RST_VALID;
        end else begin
            superpriority_q <= super_d;
        end
    end

    // ========================================================
    // Report domain: select bits at monitor level, else current
    always_comb begin
        report_dom = at_monitor_level ? security_state_select
                                      : current_domain;
    end

    // Lower pending report, shown only when sufficient
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lower_report_valid_q <= pis_pkg::RST_VALID;
            lower_report_id_q    <= '0;
        end else if (dom_impl(report_dom) && suff[report_dom]) begin
            lower_report_valid_q <= 1'b1;
            lower_report_id_q    <= highest_priority_pending_id[int'(report_dom)*ID_W +: ID_W];
        end else begin
            lower_report_valid_q <= 1'b0;
            lower_report_id_q    <= '0;
        end
    end

    // Top pending report for the monitor-level domain
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            top_report_valid_q <= pis_pkg::RST_VALID;
            top_report_id_q    <= '0;
        end else if (suff[pis_pkg::DOM_MONITOR]) begin
            top_report_valid_q <= 1'b1;
            top_report_id_q    <= highest_priority_pending_id[0 +: ID_W];
        end else begin
            top_report_valid_q <= 1'b0;
            top_report_id_q    <= '0;
        end
    end

    // ========================================================
    // Summary of the other domains; monitor bit reads zero
    always_comb begin
        summary_d    = suff;
        summary_d[0] = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            domain_pending_summary_q <= '0;
        end else begin
            domain_pending_summary_q <= summary_d;
        end
    end

endmodule
`default_nettype wire

// ### verif/pis_upstream_model.sv
// Upstream source model
`timescale 1ns/1ps
`default_nettype none
module pis_upstream_model #(
    parameter int NUM_DOM = pis_pkg::NUM_DOM
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [NUM_DOM-1:0]    want_valid,
    input  wire logic [NUM_DOM*5-1:0]  want_priority,
    input  wire logic [NUM_DOM*24-1:0] want_identifier,
    output logic      [NUM_DOM-1:0]    upstream_valid,
    output logic      [NUM_DOM*5-1:0]  upstream_priority,
    output logic      [NUM_DOM*24-1:0] upstream_identifier
);
    logic [23:0] churn_q;
    // Junk for empty slots
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            churn_q <= 24'h5a_a5c3;
        end else begin
            churn_q <= {churn_q[22:0], churn_q[23] ^ churn_q[18]};
        end
    end
    // Offered candidates, else junk
    always_comb begin
        upstream_valid = want_valid;
        for (int d = 0; d < NUM_DOM; d++) begin
            upstream_priority[d*5+:5] =
                want_valid[d] ? want_priority[d*5+:5] : churn_q[4:0];
            upstream_identifier[d*24+:24] =
                want_valid[d] ? want_identifier[d*24+:24] : churn_q;
        end
    end
endmodule
`default_nettype wire

// ### verif/pis_signaling_props.sv
// Port checks on the signaling block
`timescale 1ns/1ps
`default_nettype none
module pis_signaling_props #(
    parameter int NUM_DOM = pis_pkg::NUM_DOM,
    parameter int DOM_W   = pis_pkg::DOM_W,
    parameter int ID_W    = pis_pkg::ID_W
) (
    input wire logic               clk_sys,
    input wire logic               rst_n,
    input wire logic [NUM_DOM-1:0] domain_enable,
    input wire logic [DOM_W-1:0]   preemptive_domain_select,
    input wire logic [DOM_W-1:0]   current_domain,
    input wire logic               at_monitor_level,
    input wire logic [DOM_W-1:0]   security_state_select,
    input wire logic               nonmaskable_enable_monitor,
    input wire logic               nonmaskable_enable_routed,
    input wire logic               fast_interrupt_line_q,
    input wire logic               normal_interrupt_line_q,
    input wire logic               superpriority_q,
    input wire logic               lower_report_valid_q,
    input wire logic [ID_W-1:0]    lower_report_id_q,
    input wire logic               top_report_valid_q,
    input wire logic [ID_W-1:0]    top_report_id_q,
    input wire logic [NUM_DOM-1:0] domain_pending_summary_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Top domain held off three edges
    sequence seq_dom_off;
        !domain_enable[NUM_DOM-1] [*3];
    endsequence
    AST_DISABLED_QUIET: assert property (seq_dom_off
        |=> !domain_pending_summary_q[NUM_DOM-1])
        else $error("disabled domain pending");
    AST_LINES_EXCLUSIVE: assert property (
        !(fast_interrupt_line_q && normal_interrupt_line_q))
        else $error("both lines high");
    AST_MON_FAST: assert property (
        (top_report_valid_q || (|domain_pending_summary_q))
        && $past(current_domain) == '0 |-> fast_interrupt_line_q)
        else $error("monitor pending, no fast line");
    AST_NORMAL_NOT_MON: assert property (
        normal_interrupt_line_q |-> $past(current_domain) != '0)
        else $error("normal line in monitor domain");
    AST_NO_PREEMPT: assert property (
        $past(preemptive_domain_select) >= NUM_DOM
        && $past(current_domain) != '0 |-> !fast_interrupt_line_q)
        else $error("fast with no preemptive domain");
    AST_SUPER_ENABLE: assert property (superpriority_q |->
        (($past(current_domain) == '0) ? $past(nonmaskable_enable_monitor)
         : $past(nonmaskable_enable_routed)))
        else $error("superpriority, nonmaskable off");
    AST_SUPER_LINE: assert property (
        superpriority_q |-> fast_interrupt_line_q || normal_interrupt_line_q)
        else $error("superpriority with no line");
    AST_LOWER_SEL: assert property (
        $past(at_monitor_level) && $past(security_state_select) == '0
        |-> lower_report_valid_q == top_report_valid_q
        && lower_report_id_q == top_report_id_q)
        else $error("lower report ignores select");
    AST_LOWER_CUR: assert property (
        !$past(at_monitor_level) && $past(current_domain) == '0
        |-> lower_report_valid_q == top_report_valid_q)
        else $error("lower report ignores current domain");
    AST_SUMMARY_BIT0: assert property (
        !domain_pending_summary_q[0])
        else $error("summary reports monitor domain");
    AST_ID_ZERO: assert property (
        (!lower_report_valid_q |-> lower_report_id_q == '0)
        and (!top_report_valid_q |-> top_report_id_q == '0))
        else $error("identifier shown without pending");
endmodule
bind pis_signaling pis_signaling_props #(
    .NUM_DOM(NUM_DOM), .DOM_W(DOM_W), .ID_W(ID_W)
) i_props (
    .clk_sys, .rst_n, .domain_enable, .preemptive_domain_select,
    .current_domain, .at_monitor_level, .security_state_select,
    .nonmaskable_enable_monitor, .nonmaskable_enable_routed,
    .fast_interrupt_line_q, .normal_interrupt_line_q, .superpriority_q,
    .lower_report_valid_q, .lower_report_id_q, .top_report_valid_q,
    .top_report_id_q, .domain_pending_summary_q
);
`default_nettype wire

// ### verif/physical_interrupt_signaling_test.sv
// Bench for the signaling block
`timescale 1ns/1ps
`default_nettype none
module physical_interrupt_signaling_test;
    localparam int ND = 3;
    logic             clk_sys = 1'b0;
    logic             rst_n = 1'b0;
    logic [ND-1:0]    dom_en = '0;
    logic [ND-1:0]    up_v = '0;
    logic [ND*5-1:0]  up_p = '0;
    logic [ND*24-1:0] up_id = '0;
    logic [ND*5-1:0]  mask = '1;
    logic [ND*5-1:0]  run = '1;
    logic [ND*5-1:0]  thr = '0;
    logic [15:0]      lp = '0;
    logic [15:0]      le = '0;
    logic [79:0]      lpri = '0;
    logic [31:0]      ldom = '0;
    logic [1:0]       psel = 2'h3;
    logic [1:0]       cur = 2'h0;
    logic [1:0]       sss = 2'h0;
    logic             atmon = 1'b0;
    logic             nmm = 1'b0;
    logic             nmr = 1'b0;
    logic [ND-1:0]    m_v;
    logic [ND*5-1:0]  m_p;
    logic [ND*24-1:0] m_id;
    logic             fast, normal, sup, lv, tv;
    logic [23:0]      lid, tid;
    logic [ND-1:0]    summ;
    logic [55:0]      exp_q [$];
    int               errors = 0;
    int               n_checks = 0;
    event             ev_chk;

    // Core clock
    initial forever #12.5 clk_sys = ~clk_sys;

    pis_upstream_model #(.NUM_DOM(ND)) i_up (
        .clk_sys, .rst_n, .want_valid(up_v), .want_priority(up_p),
        .want_identifier(up_id), .upstream_valid(m_v),
        .upstream_priority(m_p), .upstream_identifier(m_id));

    pis_signaling #(.NUM_DOM(ND)) i_dut (
        .clk_sys, .rst_n, .domain_enable(dom_en), .upstream_valid(m_v),
        .upstream_priority(m_p), .upstream_identifier(m_id),
        .local_pending(lp), .local_enable(le), .local_priority(lpri),
        .local_domain(ldom), .priority_mask(mask), .running_priority(run),
        .preemption_threshold(thr), .preemptive_domain_select(psel),
        .current_domain(cur), .at_monitor_level(atmon),
        .security_state_select(sss), .nonmaskable_enable_monitor(nmm),
        .nonmaskable_enable_routed(nmr), .fast_interrupt_line_q(fast),
        .normal_interrupt_line_q(normal), .superpriority_q(sup),
        .lower_report_valid_q(lv), .lower_report_id_q(lid),
        .top_report_valid_q(tv), .top_report_id_q(tid),
        .domain_pending_summary_q(summ));

    // Reference model
    function automatic logic [55:0] model();
        logic [ND-1:0] suf;
        logic [4:0]    bp [ND];
        logic [23:0]   bi [ND];
        logic          bv, pre, lve, sp;
        logic [1:0]    rd;
        for (int d = 0; d < ND; d++) begin
            bv = up_v[d];
            bp[d] = up_p[d*5+:5];
            bi[d] = up_id[d*24+:24];
            for (int i = 0; i < 16; i++) begin
                if (lp[i] && le[i] && ldom[i*2+:2] == d
                    && (!bv || lpri[i*5+:5] < bp[d])) begin
                    bv = 1'b1;
                    bp[d] = lpri[i*5+:5];
                    bi[d] = {pis_pkg::ID_TYPE_LOCAL, 21'(i)};
                end
            end
            suf[d] = dom_en[d] && bv && bp[d] < mask[d*5+:5]
                     && bp[d] < run[d*5+:5];
            if (!suf[d]) bi[d] = '0;
        end
        pre = psel < ND && suf[psel] && bp[psel] < thr[psel*5+:5];
        rd = atmon ? sss : cur;
        lve = rd < ND && suf[rd];
        sp = cur < ND && suf[cur] && bp[cur] == pis_pkg::PRI_SUPER
             && (cur == 2'h0 ? nmm : nmr);
        return {pre || (cur == 2'h0 && |suf),
                cur != 2'h0 && !pre && cur < ND && suf[cur], sp,
                lve, lve ? bi[rd] : 24'h00_0000, suf[0], bi[0],
                suf[ND-1:1], 1'b0};
    endfunction

    // Note, settle, sample
    task automatic step();
        exp_q.push_back(model());
        repeat (4) @(posedge clk_sys);
        #2;
        -> ev_chk;
        @(negedge clk_sys);
    endtask

    task automatic set_loc(input int i, input logic [1:0] d,
                           input logic [4:0] p);
        lp[i] = 1'b1;
        le[i] = 1'b1;
        ldom[i*2+:2] = d;
        lpri[i*5+:5] = p;
    endtask

    // Random inputs
    task automatic shuffle();
        {dom_en, up_v} = (2*ND)'($urandom);
        up_p = (ND*5)'($urandom);
        up_id = (ND*24)'({$urandom, $urandom, $urandom});
        {lp, le} = $urandom;
        lpri = 80'({$urandom, $urandom, $urandom});
        ldom = $urandom;
        for (int d = 0; d < ND; d++) begin
            mask[d*5+:5] = 5'($urandom_range(31, 6));
            run[d*5+:5] = 5'($urandom_range(31, 6));
            thr[d*5+:5] = 5'($urandom);
        end
        {psel, cur, sss, atmon, nmm, nmr} = 9'($urandom);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Oldest note against outputs
    always @(ev_chk) begin : mon
        logic [55:0] got, want;
        got = {fast, normal, sup, lv, lid, tv, tid, summ};
        want = exp_q.pop_front();
        n_checks++;
        if (got !== want) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    end

    // Hang guard, six times the run
    initial begin
        #200_000;
        errors++;
        tally_and_finish();
    end

    // Directed, then random
    initial begin
        void'($urandom(32'h9fa4_100c));
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        step();
        dom_en = 3'h4;
        cur = 2'h2;
        set_loc(5, 2'h2, 5'h03);
        set_loc(9, 2'h2, 5'h03);
        step();
        up_v[2] = 1'b1;
        up_p[14:10] = 5'h03;
        up_id[71:48] = 24'h00_0abc;
        step();
        psel = 2'h2;
        thr[14:10] = 5'h04;
        step();
        psel = 2'h3;
        step();
        run[14:10] = 5'h03;
        step();
        run[14:10] = 5'h1f;
        cur = 2'h0;
        atmon = 1'b1;
        sss = 2'h2;
        step();
        cur = 2'h2;
        atmon = 1'b0;
        nmr = 1'b1;
        set_loc(1, 2'h2, 5'h00);
        step();
        dom_en = '0;
        step();
        for (int n = 0; n < 300; n++) begin
            shuffle();
            step();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
